//--- design/fdr_ramp_limiter.sv
// Functional notes
// - Smoothing off: newly calculated duty is applied immediately.
// - Smoothing on: duty change per update is bounded.
// - Control 1 bit 3 enables smoothing on output 1.
// - Control 2 bit 7 enables smoothing on output 2.
// - Control 2 bit 3 enables smoothing on output 3.
// - Period has 255 slots; duty counts high slots, one slot finest.
// - Step selectable per output: 1,2,3,5,8,12,24,48 slots.
// - Target above applied duty: raise applied duty by step.
// - Target below applied duty: lower applied duty by step.
// - Result after each step is the next comparison reference.
// - Enable and step act separately for each output.
// - Output 1 present duty register, 8-bit RW, resets to zero.
// - Output 1 step code in control 1 bits 2:0.
// - Output 2 step code in control 2 bits 6:4.
// - Output 3 step code in control 2 bits 2:0.
// - Slow bit makes the ramp four times longer.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`include "fdr_defines.svh"

module fdr_ramp_limiter
(
    input wire logic core_clk,
    input wire logic rst_n,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Calculated duties from the temperature loop
    input wire fdr_pkg::fdr_duty_t calcDuty1,
    input wire fdr_pkg::fdr_duty_t calcDuty2,
    input wire fdr_pkg::fdr_duty_t calcDuty3,
    input wire logic calcValid,
    // Fan drive outputs
    output logic fanDrive1,
    output logic fanDrive2,
    output logic fanDrive3
);
    import fdr_pkg::*;

    // =================================================================
    // Functions
    // =================================================================
    // Step code to slot count
    // All eight codes are legal, so no default branch is needed
    function automatic fdr_duty_t stepSlots(input fdr_step_code_t code);
        fdr_duty_t s;
        s = 8'h01;
        unique case (code)
            3'h0: s = 8'h01;
            3'h1: s = 8'h02;
            3'h2: s = 8'h03;
            3'h3: s = 8'h05;
            3'h4: s = 8'h08;
            3'h5: s = 8'h0C;
            3'h6: s = 8'h18;
            3'h7: s = 8'h30;
        endcase
        return s;
    endfunction

    // One bounded step toward target, landing exactly when close
    // Landing on the target instead of stepping past it keeps the duty
    // from hunting around the target at every update when the gap is
    // smaller than one step.
    function automatic fdr_duty_t rampStep(input fdr_duty_t cur,
                                           input fdr_duty_t tgt,
                                           input fdr_duty_t step);
        fdr_duty_t r;
        r = cur;
        if (tgt > cur)
        begin
            if (8'(tgt - cur) <= step)
                r = tgt;
            else
                r = 8'(cur + step);
        end
        else if (tgt < cur)
        begin
            if (8'(cur - tgt) <= step)
                r = tgt;
            else
                r = 8'(cur - step);
        end
        return r;
    endfunction

    // =================================================================
    // Registers
    // =================================================================
    // Per-output state sits in three-entry arrays indexed by output
    fdr_duty_t duty [3];
    fdr_duty_t next_duty [3];
    logic [7:0] acCtrl1;
    logic [7:0] acCtrl2;
    logic [7:0] pwmCfg [3];
    logic [1:0] slowCnt [3];
    logic [1:0] next_slowCnt [3];
    logic [7:0] next_acCtrl1;
    logic [7:0] next_acCtrl2;
    logic [7:0] next_pwmCfg [3];
    logic wbAck;
    logic next_wbAck;
    logic [31:0] rdData;
    logic [31:0] next_rdData;
    fdr_duty_t slotCnt;
    fdr_duty_t next_slotCnt;
    logic [2:0] drive;
    logic [2:0] next_drive;

    // Decoded bus request and per-output control fields
    logic wbReq;
    logic [7:0] regIdx;
    logic wrEn;
    logic [2:0] smoothEn;
    fdr_step_code_t stepSel [3];
    fdr_duty_t calc [3];

    // Bus decode; word index from byte address
    // Registers sit one per 32-bit word; only byte lane 0 holds data,
    // so a write without that lane enabled changes nothing.
    assign wbReq = wb_cyc_i && wb_stb_i && !wbAck;
    assign regIdx = wb_adr_i[9:2];
    assign wrEn = wbReq && wb_we_i && wb_sel_i[0];
    assign wb_ack_o = wbAck;
    assign wb_dat_o = rdData;

    // Per-output enable and step fields; each output reads only its own
    // bits, so two fans on one temperature channel can ramp differently
    assign smoothEn[0] = acCtrl1[`FDR_SMOOTH1_BIT];
    assign smoothEn[1] = acCtrl2[`FDR_SMOOTH2_BIT];
    assign smoothEn[2] = acCtrl2[`FDR_SMOOTH3_BIT];
    assign stepSel[0] = acCtrl1[`FDR_STEP1_LSB +: 3];
    assign stepSel[1] = acCtrl2[`FDR_STEP2_LSB +: 3];
    assign stepSel[2] = acCtrl2[`FDR_STEP3_LSB +: 3];
    assign calc[0] = calcDuty1;
    assign calc[1] = calcDuty2;
    assign calc[2] = calcDuty3;

    // =================================================================
    // Register file and duty update
    // =================================================================
    // Bus write wins over a ramp step in the same cycle, since software
    // set the duty on purpose; the ramp resumes at the next update.
    // The slow divider counts updates, not clocks, so a slowed output
    // still moves only on calculation strobes and never between them.
    always_comb
    begin
        next_acCtrl1 = acCtrl1;
        next_acCtrl2 = acCtrl2;
        for (int i = 0; i < 3; i++)
        begin
            next_pwmCfg[i] = pwmCfg[i];
            next_duty[i] = duty[i];
            next_slowCnt[i] = slowCnt[i];
            if (calcValid)
            begin
                if (!smoothEn[i])
                begin
                    next_duty[i] = calc[i];
                    next_slowCnt[i] = 2'h0;
                end
                else if (!pwmCfg[i][`FDR_SLOW_BIT] ||
                         slowCnt[i] == `FDR_SLOW_DIV)
                begin
                    // Result becomes the reference for next compare
                    next_duty[i] = rampStep(duty[i], calc[i],
                                            stepSlots(stepSel[i]));
                    next_slowCnt[i] = 2'h0;
                end
                else
                    next_slowCnt[i] = 2'(slowCnt[i] + 2'h1);
            end
        end
        if (wrEn)
        begin
            unique case (regIdx)
                `FDR_IDX_DUTY1: next_duty[0] = wb_dat_i[7:0];
                `FDR_IDX_DUTY2: next_duty[1] = wb_dat_i[7:0];
                `FDR_IDX_DUTY3: next_duty[2] = wb_dat_i[7:0];
                `FDR_IDX_PWMCFG1: next_pwmCfg[0] = wb_dat_i[7:0];
                `FDR_IDX_PWMCFG2: next_pwmCfg[1] = wb_dat_i[7:0];
                `FDR_IDX_PWMCFG3: next_pwmCfg[2] = wb_dat_i[7:0];
                `FDR_IDX_ACCTL1: next_acCtrl1 = wb_dat_i[7:0];
                `FDR_IDX_ACCTL2: next_acCtrl2 = wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Register stage for the register file
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acCtrl1 <= `FDR_ACCTL_RST;
            acCtrl2 <= `FDR_ACCTL_RST;
            for (int i = 0; i < 3; i++)
            begin
                duty[i] <= `FDR_DUTY_RST;
                pwmCfg[i] <= `FDR_PWMCFG_RST;
                slowCnt[i] <= 2'h0;
            end
        end
        else
        begin
            acCtrl1 <= next_acCtrl1;
            acCtrl2 <= next_acCtrl2;
            for (int i = 0; i < 3; i++)
            begin
                duty[i] <= next_duty[i];
                pwmCfg[i] <= next_pwmCfg[i];
                slowCnt[i] <= next_slowCnt[i];
            end
        end
    end

    // =================================================================
    // Bus answer
    // =================================================================
    // Ack and read data are registered, so every access answers exactly
    // one cycle after it is taken; wbReq masks the ack cycle itself so a
    // master that holds its strobe through ack is not served twice.
    always_comb
    begin
        next_wbAck = wbReq;
        next_rdData = rdData;
        if (wbReq)
        begin
            // Unmapped addresses read zero and still ack
            unique case (regIdx)
                `FDR_IDX_DUTY1: next_rdData = {24'h0, duty[0]};
                `FDR_IDX_DUTY2: next_rdData = {24'h0, duty[1]};
                `FDR_IDX_DUTY3: next_rdData = {24'h0, duty[2]};
                `FDR_IDX_PWMCFG1: next_rdData = {24'h0, pwmCfg[0]};
                `FDR_IDX_PWMCFG2: next_rdData = {24'h0, pwmCfg[1]};
                `FDR_IDX_PWMCFG3: next_rdData = {24'h0, pwmCfg[2]};
                `FDR_IDX_ACCTL1: next_rdData = {24'h0, acCtrl1};
                `FDR_IDX_ACCTL2: next_rdData = {24'h0, acCtrl2};
                default: next_rdData = 32'h0000_0000;
            endcase
        end
    end

    // Register stage for the bus answer; read data holds between bus accesses
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wbAck <= 1'b0;
            rdData <= 32'h0000_0000;
        end
        else
        begin
            wbAck <= next_wbAck;
            rdData <= next_rdData;
        end
    end

    // =================================================================
    // Pulse-width output
    // =================================================================
    // 255-slot period, one slot per clock; duty counts high slots.
    // A duty of 255 holds the output high for the whole period.
    // The output is registered, so it trails the slot count by a clock
    // but never glitches between slots.
    always_comb
    begin
        if (slotCnt == 8'(`FDR_SLOTS - 8'h01))
            next_slotCnt = 8'h00;
        else
            next_slotCnt = 8'(slotCnt + 8'h01);
        for (int i = 0; i < 3; i++)
            next_drive[i] = (slotCnt < duty[i]);
    end

    // Register stage for the output counter
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slotCnt <= 8'h00;
            drive <= 3'h0;
        end
        else
        begin
            slotCnt <= next_slotCnt;
            drive <= next_drive;
        end
    end

    // Drive pins straight from the output flops
    assign fanDrive1 = drive[0];
    assign fanDrive2 = drive[1];
    assign fanDrive3 = drive[2];

endmodule // fdr_ramp_limiter

//--- design/fdr_defines.svh
`ifndef FDR_DEFINES_SVH
`define FDR_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
// =====================================================================
`define FDR_IDX_DUTY1 8'h30
`define FDR_IDX_DUTY2 8'h31
`define FDR_IDX_DUTY3 8'h32
`define FDR_IDX_PWMCFG1 8'h5C
`define FDR_IDX_PWMCFG2 8'h5D
`define FDR_IDX_PWMCFG3 8'h5E
`define FDR_IDX_ACCTL1 8'h62
`define FDR_IDX_ACCTL2 8'h63

// =====================================================================
// Field positions
// =====================================================================
`define FDR_SMOOTH1_BIT 3
`define FDR_SMOOTH2_BIT 7
`define FDR_SMOOTH3_BIT 3
`define FDR_STEP1_LSB 0
`define FDR_STEP2_LSB 4
`define FDR_STEP3_LSB 0
`define FDR_SLOW_BIT 3

// =====================================================================
// Reset values
// =====================================================================
`define FDR_DUTY_RST 8'h00
`define FDR_ACCTL_RST 8'h00
`define FDR_PWMCFG_RST 8'h82

// =====================================================================
// Output period and slow-down factor
// =====================================================================
`define FDR_SLOTS 8'hFF
`define FDR_SLOW_DIV 2'h3

`endif

//--- design/fdr_pkg.sv
package fdr_pkg;
    typedef logic [7:0] fdr_duty_t;
    typedef logic [2:0] fdr_step_code_t;
endpackage

//--- verification/fdr_ramp_limiter_props.sv
`timescale 1ns/10ps
// ========
// Bus and drive checks
module fdr_ramp_limiter_props
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic calcValid,
    input wire logic fanDrive1,
    input wire logic fanDrive2,
    input wire logic fanDrive3
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic req;
    logic [2:0] fd;
    logic [2:0] prevFd;
    logic [8:0] quiet;
    logic [8:0] gap [3];
    assign req = wb_cyc_i & wb_stb_i;
    assign fd = {fanDrive3, fanDrive2, fanDrive1};
    // Period is only judged once the duty has been still for a while
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quiet <= 9'h000;
            prevFd <= 3'h0;
            for (int i = 0; i < 3; i++)
                gap[i] <= 9'h000;
        end
        else
        begin
            quiet <= (calcValid | req & wb_we_i) ? 9'h000 :
                quiet + {8'h00, quiet != 9'h1FF};
            prevFd <= fd;
            for (int i = 0; i < 3; i++)
                gap[i] <= (fd[i] & ~prevFd[i]) ? 9'h000 :
                    gap[i] + {8'h00, gap[i] != 9'h1FF};
        end
    end
    ack_after_req_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("No ack one cycle after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");
    ack_has_cause_a: assert property (wb_ack_o |-> $past(req))
        else $error("Ack without request");
    rdata_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0)
        else $error("Read data upper bits set");
    rdata_stands_a: assert property (!req |=> $stable(wb_dat_o))
        else $error("Read data changed while idle");
    period_one_a: assert property ($rose(fanDrive1) && quiet >= 9'h12C
        |-> gap[0] == 9'h0FE)
        else $error("Drive 1 period wrong");
    period_two_a: assert property ($rose(fanDrive2) && quiet >= 9'h12C
        |-> gap[1] == 9'h0FE)
        else $error("Drive 2 period wrong");
    period_three_a: assert property ($rose(fanDrive3) && quiet >= 9'h12C
        |-> gap[2] == 9'h0FE)
        else $error("Drive 3 period wrong");
    cover property ($rose(fanDrive1));
    cover property (req && wb_we_i && wb_ack_o);
    cover property (calcValid [*2]);
endmodule // fdr_ramp_limiter_props

bind fdr_ramp_limiter fdr_ramp_limiter_props fdr_ramp_limiter_props_i (
    .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
    .wb_ack_o, .calcValid, .fanDrive1, .fanDrive2, .fanDrive3);

//--- verification/fdr_fan_model.sv
`timescale 1ns/10ps
// ========
// Fan motor: reports high slots of each drive period
module fdr_fan_model
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic fanDrive,
    output fdr_pkg::fdr_duty_t measuredDuty
);
    import fdr_pkg::*;
    logic prev;
    fdr_duty_t hiCnt;
    // A rising drive starts a period; duty 0 or full never reports
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev <= 1'b0;
            hiCnt <= 8'h00;
            measuredDuty <= 8'h00;
        end
        else
        begin
            prev <= fanDrive;
            if (fanDrive & !prev)
            begin
                measuredDuty <= hiCnt;
                hiCnt <= 8'h01;
            end
            else if (fanDrive)
                hiCnt <= hiCnt + 8'h01;
        end
    end
endmodule // fdr_fan_model

//--- verification/fdr_ramp_limiter_tb_top.sv
`timescale 1ns/10ps
`include "fdr_defines.svh"
module fdr_ramp_limiter_tb_top;
    import fdr_pkg::*;
    logic core_clk, rst_n, cyc, stb, we, calcValid, ack, f1, f2, f3;
    logic [9:0] adr;
    logic [3:0] sel, bsel;
    logic [31:0] dat, rdat, rd;
    fdr_duty_t c1, c2, c3, m1, m2, m3;
    int fail_count = 0;
    int n_tests = 0;
    // Control, start duty, target, expected duty after one update
    logic [31:0] rows [11] = '{32'h0864C865, 32'h09640062, 32'h0A64C867,
        32'h0B64005F, 32'h0C64C86C, 32'h0D640058, 32'h0E64C87C,
        32'h0F640034, 32'h0F647070, 32'h0064C8C8, 32'h0FF0FFFF};
    fdr_ramp_limiter fdr_ramp_limiter_i (.core_clk, .rst_n,
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .calcDuty1(c1), .calcDuty2(c2), .calcDuty3(c3),
        .calcValid, .fanDrive1(f1), .fanDrive2(f2), .fanDrive3(f3));
    fdr_fan_model fdr_fan_model_i (.core_clk, .rst_n, .fanDrive(f1),
        .measuredDuty(m1));
    fdr_fan_model fdr_fan_model2_i (.core_clk, .rst_n, .fanDrive(f2),
        .measuredDuty(m2));
    fdr_fan_model fdr_fan_model3_i (.core_clk, .rst_n, .fanDrive(f3),
        .measuredDuty(m3));
    // ========
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [7:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= bsel;
        adr <= {idx, 2'h0};
        dat <= {24'h000000, d};
        do @(posedge core_clk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic upd(input int n);
        @(posedge core_clk);
        calcValid <= 1'b1;
        repeat (n) @(posedge core_clk);
        calcValid <= 1'b0;
    endtask
    task automatic end_sim;
        $display("Tests %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ========
    // Clock and watchdog
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial
    begin
        #1000000;
        fail_count++;
        end_sim();
    end
    // ========
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        {cyc, stb, we, calcValid} = 4'h0;
        {adr, dat, c1, c2, c3} = '0;
        {sel, bsel} = 8'hFF;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(0, `FDR_IDX_DUTY1, 8'h00);
        check(rd, 32'h0);
        bus(0, `FDR_IDX_ACCTL2, 8'h00);
        check(rd, 32'h0);
        bus(0, 8'h10, 8'h00);
        check(rd, 32'h0);
        foreach (rows[i])
        begin
            bus(1, `FDR_IDX_ACCTL1, rows[i][31:24]);
            bus(1, `FDR_IDX_DUTY1, rows[i][23:16]);
            c1 <= rows[i][15:8];
            upd(1);
            bus(0, `FDR_IDX_DUTY1, 8'h00);
            check(rd, {24'h0, rows[i][7:0]});
        end
        // Outputs two and three on their own codes, one bypassed
        bus(1, `FDR_IDX_ACCTL1, 8'h00);
        bus(1, `FDR_IDX_ACCTL2, 8'hBD);
        bus(1, `FDR_IDX_DUTY2, 8'h64);
        bus(1, `FDR_IDX_DUTY3, 8'h64);
        {c1, c2, c3} <= 24'hC8C8C8;
        upd(1);
        bus(0, `FDR_IDX_DUTY2, 8'h00);
        check(rd, 32'h69);
        bus(0, `FDR_IDX_DUTY3, 8'h00);
        check(rd, 32'h70);
        bus(0, `FDR_IDX_DUTY1, 8'h00);
        check(rd, 32'hC8);
        // Back-to-back updates build on the last result
        upd(2);
        bus(0, `FDR_IDX_DUTY2, 8'h00);
        check(rd, 32'h73);
        // Slow bit: a disabled pass clears the divider first
        bus(1, `FDR_IDX_ACCTL2, 8'h3D);
        upd(1);
        bus(1, `FDR_IDX_PWMCFG2, 8'h8A);
        bus(1, `FDR_IDX_ACCTL2, 8'hBD);
        bus(1, `FDR_IDX_DUTY2, 8'h64);
        upd(3);
        bus(0, `FDR_IDX_DUTY2, 8'h00);
        check(rd, 32'h64);
        upd(1);
        bus(0, `FDR_IDX_DUTY2, 8'h00);
        check(rd, 32'h69);
        repeat (600) @(posedge core_clk);
        check({24'h0, m1}, 32'hC8);
        check({24'h0, m2}, 32'h69);
        check({24'h0, m3}, 32'hC4);
        // A write without byte lane 0 leaves the duty alone
        bsel = 4'hE;
        bus(1, `FDR_IDX_DUTY1, 8'h55);
        bsel = 4'hF;
        bus(0, `FDR_IDX_DUTY1, 8'h00);
        check(rd, 32'hC8);
        // Mid-run reset returns duty and controls to reset values
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(0, `FDR_IDX_DUTY1, 8'h00);
        check(rd, 32'h0);
        bus(0, `FDR_IDX_PWMCFG1, 8'h00);
        check(rd, 32'h82);
        bus(0, `FDR_IDX_ACCTL1, 8'h00);
        check(rd, 32'h0);
        check({31'h0, f1}, 32'h0);
        end_sim();
    end
endmodule // fdr_ramp_limiter_tb_top
